// ===== pkg/vrc_pkg.sv
/*
 * Types shared by the voltage reference control block.
 * Assumes vrc_regs.svh is on the include path.
 */
package vrc_pkg;

`include "vrc_regs.svh"

    // ****************************************************************
    // Voltage selection codes
    // ****************************************************************
    typedef enum logic [2:0] {
        VRC_V0P55 = `VRC_CODE_0V55,
        VRC_V1P1  = `VRC_CODE_1V1,
        VRC_V2P5  = `VRC_CODE_2V5,
        VRC_V4P3  = `VRC_CODE_4V3,
        VRC_V1P5  = `VRC_CODE_1V5
    } vrc_volt_t;

    // ****************************************************************
    // One reference source as seen by its users
    // ****************************************************************
    // One-hot order: [0]=0.55V [1]=1.1V [2]=1.5V [3]=2.5V [4]=4.3V
    typedef struct packed {
        logic       enable;
        logic [2:0] code;
        logic [4:0] level_onehot;
        logic       reserved;
    } vrc_src_t;

endpackage

// ===== pkg/vrc_regs.svh
/*
 * Register map, field positions, reset values and codes of the voltage
 * reference control block.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef VRC_REGS_SVH
`define VRC_REGS_SVH

// ****************************************************************
// Register indices and byte addresses (one 32-bit word each)
// ****************************************************************
`define VRC_IDX_REF_SELECT       4'h0
`define VRC_IDX_REF_FORCE        4'h1
`define VRC_IDX_REF_STATUS       4'h2
`define VRC_ADDR_W               12
`define VRC_ADDR_REF_SELECT      12'h000
`define VRC_ADDR_REF_FORCE       12'h004
`define VRC_ADDR_REF_STATUS      12'h008

// ****************************************************************
// Field positions
// ****************************************************************
`define VRC_CONV_SEL_MSB         6
`define VRC_CONV_SEL_LSB         4
`define VRC_SHARED_SEL_MSB       2
`define VRC_SHARED_SEL_LSB       0
`define VRC_CONV_FORCE_BIT       1
`define VRC_SHARED_FORCE_BIT     0
`define VRC_STAT_CONV_EN_BIT     1
`define VRC_STAT_SHARED_EN_BIT   0
`define VRC_STAT_CONV_RES_BIT    5
`define VRC_STAT_SHARED_RES_BIT  4

// ****************************************************************
// Reset values and writable masks
// ****************************************************************
`define VRC_RST_REF_SELECT       8'h00
`define VRC_RST_REF_FORCE        8'h00
`define VRC_MASK_REF_SELECT      8'h77
`define VRC_MASK_REF_FORCE       8'h03

// ****************************************************************
// Selection codes
// ****************************************************************
`define VRC_CODE_0V55            3'h0
`define VRC_CODE_1V1             3'h1
`define VRC_CODE_2V5             3'h2
`define VRC_CODE_4V3             3'h3
`define VRC_CODE_1V5             3'h4

`endif

// ===== verification/vrc_req_model.sv
/* Requesting peripherals: converter, comparator and DAC request lines.
   Assumes the bench asks on clk_sys; slow adds one cycle of lag. */
`timescale 1ns/1ps
module vrc_req_model (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       arst_n,
    // Bench command {converter, comparator, dac}
    input wire logic [2:0] want,
    input wire logic       slow,
    // Requests
    output logic           converter_req,
    output logic           comparator_req,
    output logic           dac_req
);
    logic [5:0] dly_ff;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) dly_ff <= 6'h00;
        else dly_ff <= {dly_ff[2:0], want};
    end
    assign {converter_req, comparator_req, dac_req} = slow ? dly_ff[5:3] : dly_ff[2:0];
endmodule // vrc_req_model

// ===== verification/vrc_top_monitor.sv
/* Assertion checker for vrc_top.
   Assumes it is bound to vrc_top and sees only that module's ports. */
`timescale 1ns/1ps
module vrc_top_monitor
    import vrc_pkg::*;
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        arst_n,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    // Requests and sources
    input wire logic        converter_req,
    input wire logic        comparator_req,
    input wire logic        dac_req,
    input wire vrc_src_t    converter_ref,
    input wire vrc_src_t    shared_analog_ref
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    conv_req_on_a: assert property (converter_req |=> converter_ref.enable)
        else $error("converter source off while requested");
    shared_req_on_a: assert property ((comparator_req || dac_req) |=> shared_analog_ref.enable)
        else $error("shared source off while requested");
    idle_rdata_a: assert property (!(psel && penable) |-> prdata == 32'h0)
        else $error("read data not zero outside access");
    conv_level_a: assert property (converter_ref.code == 3'h4 |-> converter_ref.level_onehot == 5'h04)
        else $error("code four does not give the 1.5V level");
    reserved_code_a: assert property (converter_ref.code > 3'h4 |-> converter_ref.reserved && converter_ref.level_onehot == 5'h00)
        else $error("reserved code selects a level");
    unused_bits_a: assert property (psel && penable && !pwrite && paddr == 12'h000 |-> prdata[7] == 1'b0 && prdata[3] == 1'b0)
        else $error("unused select bits read nonzero");
    select_follow_a: assert property (psel && penable && pwrite && pstrb[0] && paddr == 12'h000 |=> ##1 shared_analog_ref.code == $past(pwdata[2:0], 2))
        else $error("shared code does not follow the write");
    force_on_a: assert property (psel && penable && pwrite && pstrb[0] && paddr == 12'h004 && pwdata[1] |=> ##1 converter_ref.enable)
        else $error("forced converter source not running");
endmodule // vrc_top_monitor

bind vrc_top vrc_top_monitor vrc_top_monitor_i (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .converter_req(converter_req), .comparator_req(comparator_req),
    .dac_req(dac_req), .converter_ref(converter_ref), .shared_analog_ref(shared_analog_ref));

// ===== verification/vrc_top_tb_top.sv
/* Self-checking bench for vrc_top: APB master tasks and request model.
   Assumes the package, checker and request model are compiled first. */
`timescale 1ns/1ps
module vrc_top_tb_top
    import vrc_pkg::*;
;
    logic        clk_sys = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hf;
    logic [2:0]  want = 3'h0;
    logic        pready, pslverr, err, converter_req, comparator_req, dac_req;
    vrc_src_t    converter_ref, shared_analog_ref;
    int          num_errors = 0, checked = 0;
    always #50 clk_sys = ~clk_sys;
    vrc_top vrc_top_i (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .converter_req(converter_req),
        .comparator_req(comparator_req), .dac_req(dac_req), .converter_ref(converter_ref),
        .shared_analog_ref(shared_analog_ref));
    vrc_req_model vrc_req_model_i (.clk_sys(clk_sys), .arst_n(arst_n), .want(want),
        .slow(slow), .converter_req(converter_req), .comparator_req(comparator_req),
        .dac_req(dac_req));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Wait as long as the slave stretches; only the watchdog ends it
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Outputs are registered: settle two edges, sample mid-cycle
    task automatic look;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic ask(input logic [2:0] w);
        @(posedge clk_sys);
        want <= w;
        look;
        look;
    endtask
    function automatic logic [31:0] src(input logic en, input logic [2:0] c);
        logic [4:0] oh;
        oh = c == 3'h0 ? 5'h01 : c == 3'h1 ? 5'h02 : c == 3'h2 ? 5'h08 :
             c == 3'h3 ? 5'h10 : c == 3'h4 ? 5'h04 : 5'h00;
        return {22'h0, en, c, oh, c > 3'h4};
    endfunction
    task automatic t_reset;
        apb(1'b0, 12'h000, 32'h0);
        chk("select", 32'h0, rd);
        apb(1'b0, 12'h004, 32'h0);
        chk("force", 32'h0, rd);
        look;
        chk("conv_src", src(1'b0, 3'h0), 32'(converter_ref));
        chk("shared_src", src(1'b0, 3'h0), 32'(shared_analog_ref));
        $display("test reset done");
    endtask
    // Every code on both fields, with unused bits written high
    task automatic t_codes;
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, 12'h000, {24'h0, 1'b1, 3'(c), 1'b1, 3'(7 - c)});
            apb(1'b0, 12'h000, 32'h0);
            chk("select_rd", {24'h0, 1'b0, 3'(c), 1'b0, 3'(7 - c)}, rd);
            look;
            chk("conv_src", src(1'b0, 3'(c)), 32'(converter_ref));
            chk("shared_src", src(1'b0, 3'(7 - c)), 32'(shared_analog_ref));
            apb(1'b0, 12'h008, 32'h0);
            chk("status_res", {26'h0, c > 4, c < 3, 4'h0}, rd);
        end
        $display("test codes done");
    endtask
    task automatic t_force;
        apb(1'b1, 12'h004, 32'hffff_ffff);
        apb(1'b0, 12'h004, 32'h0);
        chk("force_rd", 32'h3, rd);
        look;
        chk("conv_on", 32'h1, 32'(converter_ref.enable));
        apb(1'b0, 12'h008, 32'h0);
        chk("status_forced", 32'h23, rd);
        apb(1'b1, 12'h004, 32'h1);
        look;
        chk("conv_off", 32'h0, 32'(converter_ref.enable));
        chk("shared_on", 32'h1, 32'(shared_analog_ref.enable));
        apb(1'b1, 12'h004, 32'h0);
        look;
        chk("shared_off", 32'h0, 32'(shared_analog_ref.enable));
        $display("test force done");
    endtask
    // Each request alone, prompt and slow
    task automatic t_req;
        for (int i = 0; i < 6; i++) begin
            slow <= i[0];
            ask(3'h1 << (i / 2));
            chk("conv_en", 32'(i / 2 == 2), 32'(converter_ref.enable));
            chk("shared_en", 32'(i / 2 < 2), 32'(shared_analog_ref.enable));
            ask(3'h0);
            chk("both_off", 32'h0, 32'({converter_ref.enable, shared_analog_ref.enable}));
        end
        $display("test requests done");
    endtask
    task automatic t_bad;
        apb(1'b1, 12'h00c, 32'hff);
        chk("slverr_wr", 32'h1, 32'(err));
        apb(1'b0, 12'h00c, 32'h0);
        chk("slverr_rd", 32'h1, 32'(err));
        apb(1'b1, 12'h008, 32'hff);
        chk("status_wr_err", 32'h0, 32'(err));
        pstrb <= 4'he;
        apb(1'b1, 12'h000, 32'h11);
        pstrb <= 4'hf;
        apb(1'b0, 12'h000, 32'h0);
        chk("strobe_off", 32'h70, rd);
        chk("slverr_ok", 32'h0, 32'(err));
        $display("test unmapped done");
    endtask
    // Mid-run reset brings registers and sources back to defaults
    task automatic t_rst;
        apb(1'b1, 12'h000, 32'h24);
        apb(1'b1, 12'h004, 32'h3);
        look;
        apb(1'b0, 12'h008, 32'h0);
        chk("status_on", 32'h3, rd);
        @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        look;
        chk("rst_conv", src(1'b0, 3'h0), 32'(converter_ref));
        chk("rst_shared", src(1'b0, 3'h0), 32'(shared_analog_ref));
        apb(1'b0, 12'h000, 32'h0);
        chk("rst_select", 32'h0, rd);
        apb(1'b0, 12'h004, 32'h0);
        chk("rst_force", 32'h0, rd);
        $display("test mid-run reset done");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_reset;
        t_codes;
        t_force;
        t_req;
        t_bad;
        t_rst;
        end_sim;
    end
    // Whole run is well under 1000 cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        num_errors++;
        end_sim;
    end
endmodule // vrc_top_tb_top

// ===== verilog/vrc_ref_src.sv
/*
 * One reference source: enable decision and level decode, registered.
 * Assumes select code, force bit and request all on clk_sys.
 */
`timescale 1ns/1ps

module vrc_ref_src
    import vrc_pkg::*;
(
    // Clock and reset
    input  wire logic     clk_sys,
    input  wire logic     arst_n,
    // Control
    input  wire logic [2:0] sel_code,
    input  wire logic       force_on,
    input  wire logic       request,
    // Source state
    output vrc_src_t        src_ff
);

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire logic       nxt_enable;
    wire logic [4:0] nxt_onehot;
    wire logic       nxt_reserved;

    // Request alone, or force; off when neither
    assign nxt_enable = request | force_on;

    assign nxt_onehot[0] = (sel_code == VRC_V0P55);
    assign nxt_onehot[1] = (sel_code == VRC_V1P1);
    assign nxt_onehot[2] = (sel_code == VRC_V1P5);
    assign nxt_onehot[3] = (sel_code == VRC_V2P5);
    assign nxt_onehot[4] = (sel_code == VRC_V4P3);
    // Reserved codes select no level at all
    assign nxt_reserved  = (sel_code > VRC_V1P5);

    // ****************************************************************
    // State
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            src_ff <= '{enable: 1'b0, code: 3'h0, level_onehot: 5'h01, reserved: 1'b0};
        end else begin
            src_ff <= '{enable: nxt_enable, code: sel_code,
                        level_onehot: nxt_onehot, reserved: nxt_reserved};
        end
    end

endmodule // vrc_ref_src

// ===== verilog/vrc_top.sv
/*
 * Voltage reference control: APB register slave and the enable logic for
 * the converter source and the shared comparator/DAC source. Also holds a
 * read-only status word with the live enable and reserved-code flags of
 * both sources.
 * Assumes APB master and the requesting peripherals run on clk_sys, so
 * no request is synchronised here; an asynchronous requester needs its
 * own two-stage synchroniser in front of this block.
 * Assumes zero wait states are acceptable to the master; pready is
 * tied high.
 */
// Local design decision: the APB slave port.
`timescale 1ns/1ps

`include "vrc_regs.svh"

module vrc_top
    import vrc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Peripheral requests
    input  wire logic        converter_req,
    input  wire logic        comparator_req,
    input  wire logic        dac_req,
    // Reference sources
    output vrc_src_t         converter_ref,
    output vrc_src_t         shared_analog_ref
);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [7:0]  ref_select_ff;
    logic [7:0]  ref_force_ff;
    logic [31:0] prdata_ff;
    logic        pslverr_ff;

    logic [7:0]  nxt_ref_select;
    logic [7:0]  nxt_ref_force;
    logic [31:0] nxt_prdata;
    logic        nxt_pslverr;

    // ****************************************************************
    // Register fields
    // ****************************************************************
    wire logic [2:0] conv_sel;
    wire logic [2:0] shared_sel;
    wire logic       conv_force;
    wire logic       shared_force;

    // Field slices named once, so instances and status agree
    assign conv_sel     = ref_select_ff[`VRC_CONV_SEL_MSB:`VRC_CONV_SEL_LSB];
    assign shared_sel   = ref_select_ff[`VRC_SHARED_SEL_MSB:`VRC_SHARED_SEL_LSB];
    assign conv_force   = ref_force_ff[`VRC_CONV_FORCE_BIT];
    assign shared_force = ref_force_ff[`VRC_SHARED_FORCE_BIT];

    // ****************************************************************
    // Transfer phases
    // ****************************************************************
    wire logic access_phase;
    wire logic setup_phase;
    wire logic rd_setup;

    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign rd_setup     = setup_phase & ~pwrite;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire logic miss_addr;
    wire logic hit_select;
    wire logic hit_force;
    wire logic hit_status;
    wire logic hit_any;
    wire logic wr_lane0;
    wire logic wr_select;
    wire logic wr_force;

    assign hit_select   = (paddr == `VRC_ADDR_REF_SELECT);
    assign hit_force    = (paddr == `VRC_ADDR_REF_FORCE);
    assign hit_status   = (paddr == `VRC_ADDR_REF_STATUS);
    assign hit_any      = hit_select | hit_force | hit_status;
    assign miss_addr    = ~hit_any;
    // Only byte lane 0 carries register bits
    assign wr_lane0     = access_phase & pwrite & pstrb[0];
    assign wr_select    = wr_lane0 & hit_select;
    assign wr_force     = wr_lane0 & hit_force;

    // ****************************************************************
    // Write path
    // ****************************************************************
    wire logic [7:0] wdata_select;
    wire logic [7:0] wdata_force;

    // Unused bits never stored, so they can only read back as zero
    assign wdata_select   = pwdata[7:0] & `VRC_MASK_REF_SELECT;
    assign wdata_force    = pwdata[7:0] & `VRC_MASK_REF_FORCE;
    assign nxt_ref_select = wr_select ? wdata_select : ref_select_ff;
    assign nxt_ref_force  = wr_force  ? wdata_force  : ref_force_ff;

    // ****************************************************************
    // Read path
    // ****************************************************************
    wire logic [7:0] status_byte;
    wire logic [7:0] rd_byte;

    // Live source state for software; lets it see a pending request
    assign status_byte[7:6]                      = 2'h0;
    assign status_byte[`VRC_STAT_CONV_RES_BIT]   = converter_ref.reserved;
    assign status_byte[`VRC_STAT_SHARED_RES_BIT] = shared_analog_ref.reserved;
    assign status_byte[3:2]                      = 2'h0;
    assign status_byte[`VRC_STAT_CONV_EN_BIT]    = converter_ref.enable;
    assign status_byte[`VRC_STAT_SHARED_EN_BIT]  = shared_analog_ref.enable;

    assign rd_byte = hit_select ? ref_select_ff :
                     hit_force  ? ref_force_ff  :
                     hit_status ? status_byte   : 8'h00;

    // Read data captured in setup so it stands through the access phase
    assign nxt_prdata  = rd_setup     ? {24'h000000, rd_byte} :
                         access_phase ? prdata_ff : 32'h00000000;
    // Unmapped addresses answer with an error; status writes are ignored
    assign nxt_pslverr = setup_phase ? miss_addr :
                         access_phase ? pslverr_ff : 1'b0;

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ref_select_ff <= `VRC_RST_REF_SELECT;
        end else begin
            ref_select_ff <= nxt_ref_select;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ref_force_ff <= `VRC_RST_REF_FORCE;
        end else begin
            ref_force_ff <= nxt_ref_force;
        end
    end

    // ****************************************************************
    // Read capture
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prdata_ff <= 32'h00000000;
        end else begin
            prdata_ff <= nxt_prdata;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pslverr_ff <= 1'b0;
        end else begin
            pslverr_ff <= nxt_pslverr;
        end
    end

    // ****************************************************************
    // Bus outputs
    // ****************************************************************
    // Zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign prdata  = access_phase ? prdata_ff : 32'h00000000;
    assign pslverr = access_phase & pslverr_ff;

    // ****************************************************************
    // Reference sources
    // ****************************************************************
    wire logic shared_req;

    // Either shared user may hold the source on
    assign shared_req = comparator_req | dac_req;

    // ****************************************************************
    // Source instances
    // ****************************************************************

    vrc_ref_src u_converter_src (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .sel_code (conv_sel),
        .force_on (conv_force),
        .request  (converter_req),
        .src_ff   (converter_ref)
    );

    vrc_ref_src u_shared_src (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .sel_code (shared_sel),
        .force_on (shared_force),
        .request  (shared_req),
        .src_ff   (shared_analog_ref)
    );

endmodule // vrc_top
